// *** ptb_timer_base.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module ptb_timer_base #(
  parameter ptb_pkg::ptb_subtype_e SUBTYPE   = ptb_pkg::PTB_ADV6,
  parameter int                    PSC_W     = 16,
  parameter logic [31:0]           INIT_CNT  = 32'h0000_0000,
  parameter bit                    INIT_DOWN = 1'b0
) (
  input  wire logic                                  CLK_IN,
  input  wire logic                                  SYS_RST_IN,
  input  wire ptb_pkg::ptb_bus_s                     BUS_IN,
  input  wire ptb_pkg::ptb_dyn_s                     DYN_IN,
  input  wire logic [15:0]                           OUT_ENABLE_POL_IN,
  input  wire logic                                  SYNC_IN,
  output logic [31:0]                                RDATA_OUT,
  output logic [31:0]                                COUNT_OUT,
  output logic                                       COUNT_TICK_OUT,
  output logic                                       UPDATE_FLAG_PULSE_OUT,
  output logic [ptb_pkg::MAX_CH-1:0]                 COMPARE_FLAG_PULSE_OUT,
  output logic                                       COUNT_DOWN_OUT,
  output ptb_pkg::ptb_dyn_s                          ACTIVE_DYN_OUT,
  output logic [15:0]                                OUT_ENABLE_POL_OUT,
  output logic [1:0]                                 DEADTIME_DIV_OUT
);
  // channel count and width follow subtype
  localparam int CW = (SUBTYPE == ptb_pkg::PTB_GP4W) ? 32 : 16;
  localparam int NCH = (SUBTYPE == ptb_pkg::PTB_ADV6) ? 6 :
                       (SUBTYPE == ptb_pkg::PTB_CP2) ? 2 :
                       (SUBTYPE == ptb_pkg::PTB_CP1) ? 1 : 4;

  // refuse widths the divider and bus cannot hold
  if (PSC_W < 1 || PSC_W > 32) begin : g_psc_check
    $error("prescaler width out of range");
  end
  // a 16-bit counter cannot start above its range
  if (CW == 16 && INIT_CNT[31:16] != 16'h0000) begin : g_init_check
    $error("initial count wider than counter");
  end

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0]                     ctrl;
    logic [PSC_W-1:0]                psc;
    logic [PSC_W-1:0]                div;
    logic [31:0]                     cnt;
    ptb_pkg::ptb_dir_e               dir;
    logic                            sync_q;
    ptb_pkg::ptb_dyn_s               act;
    logic                            tick;
    logic                            upd;
    logic [ptb_pkg::MAX_CH-1:0]      cmp;
    logic [31:0]                     rdata;
    logic [15:0]                     oep;
  } ptb_state_s;

  ptb_state_s st_ff;
  ptb_state_s nxt_st;

  function automatic logic [31:0] mask_w(input logic [31:0] v);
    mask_w = (CW == 32) ? v : {16'h0000, v[15:0]};
  endfunction : mask_w

  logic [1:0]  alignment_select;
  logic        edge_down;
  logic [31:0] rld;
  logic        sync_rise;
  logic        ovf;
  logic        udf;
  logic        at_ev;

  always_comb begin
    nxt_st    = st_ff;
    alignment_select       = st_ff.ctrl[ptb_pkg::BIT_CMS_LO +: 2];
    edge_down = st_ff.ctrl[ptb_pkg::BIT_DIR];
    rld       = mask_w(st_ff.act.reload);
    sync_rise = SYNC_IN && !st_ff.sync_q;
    ovf       = 1'b0;
    udf       = 1'b0;
    at_ev     = 1'b0;
    nxt_st.sync_q = SYNC_IN;
    nxt_st.tick   = 1'b0;
    nxt_st.upd    = 1'b0;
    nxt_st.cmp    = '0;
    nxt_st.rdata  = 32'h0000_0000;
    // enable/polarity acts immediately, never preloaded
    nxt_st.oep    = OUT_ENABLE_POL_IN;

    // prescaler; enable bit ignored, counter always runs
    if (st_ff.div >= st_ff.psc) begin
      nxt_st.div  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 1'b1;
    end

    if (nxt_st.tick) begin
      if (alignment_select == ptb_pkg::CMS_EDGE) begin
        if (!edge_down) begin
          nxt_st.dir = ptb_pkg::PTB_UP;
          if (st_ff.cnt >= rld) begin
            nxt_st.cnt = 32'h0000_0000;
            ovf        = 1'b1;
          end else begin
            nxt_st.cnt = mask_w(st_ff.cnt + 32'h0000_0001);
          end
        end else begin
          nxt_st.dir = ptb_pkg::PTB_DOWN;
          if (st_ff.cnt == 32'h0000_0000) begin
            nxt_st.cnt = rld;
            udf        = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
          end
        end
      end else begin
        // 2*reload ticks per period, turn at 0 and reload
        case (st_ff.dir)
          ptb_pkg::PTB_UP: begin
            if (st_ff.cnt + 32'h0000_0001 >= rld) begin
              nxt_st.cnt = rld;
              nxt_st.dir = ptb_pkg::PTB_DOWN;
              ovf        = 1'b1;
            end else begin
              nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
            end
          end
          ptb_pkg::PTB_DOWN: begin
            if (st_ff.cnt <= 32'h0000_0001) begin
              nxt_st.cnt = 32'h0000_0000;
              nxt_st.dir = ptb_pkg::PTB_UP;
              udf        = 1'b1;
            end else begin
              nxt_st.cnt = st_ff.cnt - 32'h0000_0001;
            end
          end
          default: begin
            nxt_st.dir = ptb_pkg::PTB_UP;
          end
        endcase
      end
      // compare match on the new count value, output only
      for (int i = 0; i < NCH; i++) begin
        if (mask_w(st_ff.act.compare[i*32 +: 32]) == nxt_st.cnt) begin
          case (alignment_select)
            ptb_pkg::CMS_EDGE: nxt_st.cmp[i] = 1'b1;
            ptb_pkg::CMS_DOWN: nxt_st.cmp[i] = (nxt_st.dir == ptb_pkg::PTB_DOWN);
            ptb_pkg::CMS_UP:   nxt_st.cmp[i] = (nxt_st.dir == ptb_pkg::PTB_UP);
            default:           nxt_st.cmp[i] = 1'b1;
          endcase
        end
      end
    end

    // every wrap is an update event, no repetition count
    at_ev = ovf || udf;
    nxt_st.upd = at_ev;
    if (at_ev) begin
      nxt_st.act = DYN_IN;
    end

    // sync clears counter and loads pending settings
    if (sync_rise) begin
      nxt_st.cnt = 32'h0000_0000;
      nxt_st.act = DYN_IN;
      nxt_st.div = '0;
    end

    // register port; static settings take any write at once, no preload
    if (BUS_IN.wr) begin
      case (BUS_IN.addr)
        ptb_pkg::ADDR_CTRL: nxt_st.ctrl = BUS_IN.wdata[15:0] & ptb_pkg::CTRL_MASK;
        ptb_pkg::ADDR_PSC:  nxt_st.psc  = BUS_IN.wdata[PSC_W-1:0];
        default: ;
      endcase
    end
    if (BUS_IN.rd) begin
      case (BUS_IN.addr)
        ptb_pkg::ADDR_CTRL:   nxt_st.rdata = {16'h0000, st_ff.ctrl};
        ptb_pkg::ADDR_PSC:    nxt_st.rdata = 32'(st_ff.psc);
        ptb_pkg::ADDR_STATUS: nxt_st.rdata = {30'h0000_0000, st_ff.dir == ptb_pkg::PTB_DOWN, st_ff.tick};
        ptb_pkg::ADDR_COUNT:  nxt_st.rdata = st_ff.cnt;
        ptb_pkg::ADDR_RELOAD: nxt_st.rdata = rld;
        default:              nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      st_ff      <= '0;
      st_ff.ctrl <= ptb_pkg::CTRL_RST;
      st_ff.cnt  <= INIT_CNT;
      st_ff.dir  <= INIT_DOWN ? ptb_pkg::PTB_DOWN : ptb_pkg::PTB_UP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign RDATA_OUT              = st_ff.rdata;
  assign COUNT_OUT              = st_ff.cnt;
  assign COUNT_TICK_OUT         = st_ff.tick;
  assign UPDATE_FLAG_PULSE_OUT  = st_ff.upd;
  assign COMPARE_FLAG_PULSE_OUT = st_ff.cmp;
  assign COUNT_DOWN_OUT         = (st_ff.dir == ptb_pkg::PTB_DOWN);
  assign ACTIVE_DYN_OUT         = st_ff.act;
  assign OUT_ENABLE_POL_OUT     = st_ff.oep;
  // dead-time divide only for dead-time subtypes
  assign DEADTIME_DIV_OUT = (SUBTYPE == ptb_pkg::PTB_GP4W || SUBTYPE == ptb_pkg::PTB_GP4) ? 2'h0 :
                            st_ff.ctrl[ptb_pkg::BIT_CKD_LO +: 2];

  ////////////////////////////////////////////////////////////////////////
  property p_tick_spacing;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (COUNT_TICK_OUT && st_ff.psc == '0 && !sync_rise) |=> COUNT_TICK_OUT;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick missing");

  property p_up_wrap;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (nxt_st.tick && alignment_select == ptb_pkg::CMS_EDGE && !edge_down && st_ff.cnt >= rld && !sync_rise)
      |=> (COUNT_OUT == 32'h0000_0000 && UPDATE_FLAG_PULSE_OUT);
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up wrap wrong");

  property p_down_wrap;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (nxt_st.tick && alignment_select == ptb_pkg::CMS_EDGE && edge_down && st_ff.cnt == 32'h0000_0000 && !sync_rise)
      |=> (COUNT_OUT == $past(rld) && UPDATE_FLAG_PULSE_OUT);
  endproperty
  a_down_wrap: assert property (p_down_wrap) else $error("down wrap wrong");

  property p_upd_pulse;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (UPDATE_FLAG_PULSE_OUT && st_ff.psc != '0) |=> !UPDATE_FLAG_PULSE_OUT;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update not a pulse");

  property p_load_at_update;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!at_ev && !sync_rise) |=> $stable(ACTIVE_DYN_OUT);
  endproperty
  a_load_at_update: assert property (p_load_at_update) else $error("settings changed early");

  property p_sync;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (SYNC_IN && !st_ff.sync_q) |=> (COUNT_OUT == 32'h0000_0000 && ACTIVE_DYN_OUT == $past(DYN_IN));
  endproperty
  a_sync: assert property (p_sync) else $error("sync not applied");

  property p_cms_up_only;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (alignment_select == ptb_pkg::CMS_UP && nxt_st.dir == ptb_pkg::PTB_DOWN) |=> COMPARE_FLAG_PULSE_OUT == '0;
  endproperty
  a_cms_up_only: assert property (p_cms_up_only) else $error("flag while counting down");

  property p_center_turn;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (alignment_select != ptb_pkg::CMS_EDGE && COUNT_DOWN_OUT && UPDATE_FLAG_PULSE_OUT && !$past(sync_rise))
      |-> COUNT_OUT == $past(rld);
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center turn wrong");

  property p_oep_direct;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    1'b1 |=> OUT_ENABLE_POL_OUT == $past(OUT_ENABLE_POL_IN);
  endproperty
  a_oep_direct: assert property (p_oep_direct) else $error("enable/polarity preloaded");

  // covers the divided case the spacing check leaves out
  property p_tick_gap;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (COUNT_TICK_OUT && st_ff.psc != '0) |=> !COUNT_TICK_OUT;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too early");

  property p_no_tick_hold;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (!nxt_st.tick && !sync_rise) |=> $stable(COUNT_OUT);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved without tick");

  property p_edge_step_up;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (nxt_st.tick && alignment_select == ptb_pkg::CMS_EDGE && !edge_down && st_ff.cnt < rld && !sync_rise)
      |=> COUNT_OUT == $past(st_ff.cnt) + 32'h0000_0001;
  endproperty
  a_edge_step_up: assert property (p_edge_step_up) else $error("up step wrong");

  property p_edge_step_down;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (nxt_st.tick && alignment_select == ptb_pkg::CMS_EDGE && edge_down && st_ff.cnt != 32'h0000_0000 && !sync_rise)
      |=> COUNT_OUT == $past(st_ff.cnt) - 32'h0000_0001;
  endproperty
  a_edge_step_down: assert property (p_edge_step_down) else $error("down step wrong");

  property p_dir_edge;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (nxt_st.tick && alignment_select == ptb_pkg::CMS_EDGE) |=> COUNT_DOWN_OUT == $past(edge_down);
  endproperty
  a_dir_edge: assert property (p_dir_edge) else $error("edge direction wrong");

  property p_center_floor;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (alignment_select != ptb_pkg::CMS_EDGE && !COUNT_DOWN_OUT && UPDATE_FLAG_PULSE_OUT && !$past(sync_rise))
      |-> COUNT_OUT == 32'h0000_0000;
  endproperty
  a_center_floor: assert property (p_center_floor) else $error("center floor wrong");

  property p_cms_down_only;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (alignment_select == ptb_pkg::CMS_DOWN && nxt_st.dir == ptb_pkg::PTB_UP) |=> COMPARE_FLAG_PULSE_OUT == '0;
  endproperty
  a_cms_down_only: assert property (p_cms_down_only) else $error("flag while counting up");

  // old compare value applies in the cycle a new one loads
  property p_cmp_match;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (COMPARE_FLAG_PULSE_OUT[0] && !$past(sync_rise))
      |-> mask_w(COUNT_OUT) == mask_w($past(ACTIVE_DYN_OUT.compare[31:0]));
  endproperty
  a_cmp_match: assert property (p_cmp_match) else $error("flag without match");

  property p_upd_on_tick;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    UPDATE_FLAG_PULSE_OUT |-> COUNT_TICK_OUT;
  endproperty
  a_upd_on_tick: assert property (p_upd_on_tick) else $error("update off tick");

  property p_cmp_on_tick;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (COMPARE_FLAG_PULSE_OUT != '0) |-> COUNT_TICK_OUT;
  endproperty
  a_cmp_on_tick: assert property (p_cmp_on_tick) else $error("compare flag off tick");

  property p_rdata_idle;
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    !BUS_IN.rd |=> RDATA_OUT == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
endmodule : ptb_timer_base

// *** ptb_pkg.sv ***
// Overview of operation
// - count tick fires once every prescaler_divisor plus one clocks.
// - edge-aligned up counts zero to reload, wraps, update event at overflow.
// - edge-aligned down counts reload to zero, reloads, update event at underflow.
// - edge-aligned period equals reload plus one count ticks.
// - center-aligned reverses at both ends, update event at each end.
// - center-aligned full period equals twice reload in count ticks.
// - compare flag per channel when counter equals compare value, mode qualified.
// - compare, reload and output compare modes take effect only at update events and rising sync edges.
// - dynamic inputs sampled at update events; enable/polarity register acts at once.
// - alignment_select 00 edge, 01 down flags, 10 up flags, 11 both.
// - edge-aligned direction bit 0 counts up, 1 counts down.
// - one 16-bit control register holds mode, direction, preload, update, enable.
// - counter always runs and update events are always enabled.
// - no single-pulse mode; counter runs continuously.
// - no repetition counter; every overflow or underflow gives an update event.
// - no input capture; channels act only as outputs.
// - subtypes: 6ch 16bit, 4ch 32bit, 4ch 16bit, 2ch and 1ch 16bit.
// - dead-time clock divide only matters for dead-time subtypes.
// - rising sync edge clears counter and loads pending dynamic settings.
// - update and compare flags are single-cycle pulses while the prescaler value is nonzero.
// - initial counter value and initial direction are configurable.
package ptb_pkg;
  localparam int          MAX_CH        = 6;
  localparam int          MAX_W         = 32;
  localparam int          CTRL_W        = 16;
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_PSC      = 4'h1;
  localparam logic [3:0]  ADDR_STATUS   = 4'h2;
  localparam logic [3:0]  ADDR_COUNT    = 4'h3;
  localparam logic [3:0]  ADDR_RELOAD   = 4'h4;
  localparam int          BIT_EN        = 0;
  localparam int          BIT_UPDATE_DISABLE      = 1;
  localparam int          BIT_URS       = 2;
  localparam int          BIT_SPM       = 3;
  localparam int          BIT_DIR       = 4;
  localparam int          BIT_CMS_LO    = 5;
  localparam int          BIT_RELOAD_PRELOAD_ENABLE      = 7;
  localparam int          BIT_CKD_LO    = 8;
  localparam logic [15:0] CTRL_RST      = 16'h0081;
  localparam logic [15:0] CTRL_MASK     = 16'h03FF;
  localparam logic [1:0]  CMS_EDGE      = 2'h0;
  localparam logic [1:0]  CMS_DOWN      = 2'h1;
  localparam logic [1:0]  CMS_UP        = 2'h2;
  localparam logic [1:0]  CMS_BOTH      = 2'h3;

  typedef enum logic [2:0] {
    PTB_ADV6  = 3'h0,
    PTB_GP4W  = 3'h1,
    PTB_GP4   = 3'h2,
    PTB_CP2   = 3'h3,
    PTB_CP1   = 3'h4
  } ptb_subtype_e;

  typedef enum logic [1:0] {
    PTB_UP   = 2'b01,
    PTB_DOWN = 2'b10
  } ptb_dir_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ptb_bus_s;

  typedef struct packed {
    logic [MAX_W-1:0]        reload;
    logic [MAX_CH*MAX_W-1:0] compare;
    logic [MAX_CH*4-1:0]     oc_mode;
  } ptb_dyn_s;
endpackage : ptb_pkg

// *** ptb_timer_base_test.sv ***
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", nm, exp, got); end end

module ptb_timer_base_test;
  localparam logic [31:0] INIT = 32'h0000_0002;
  logic              clk;
  logic              rst;
  ptb_pkg::ptb_bus_s bus;
  ptb_pkg::ptb_dyn_s dyn;
  logic [15:0]       oep;
  logic              sync;
  logic [31:0]       rdata;
  logic [31:0]       count;
  logic              tick;
  logic              upd;
  logic [5:0]        cmpf;
  logic              down;
  ptb_pkg::ptb_dyn_s act;
  logic [15:0]       oep_q;
  logic [1:0]        dtd;
  int                fail_count = 0;
  int                tests_run  = 0;
  int                cyc        = 0;

  ptb_timer_base #(.SUBTYPE(ptb_pkg::PTB_ADV6), .PSC_W(16), .INIT_CNT(INIT), .INIT_DOWN(1'b0)) ptb_timer_base_i (
    .CLK_IN                 (clk),
    .SYS_RST_IN             (rst),
    .BUS_IN                 (bus),
    .DYN_IN                 (dyn),
    .OUT_ENABLE_POL_IN      (oep),
    .SYNC_IN                (sync),
    .RDATA_OUT              (rdata),
    .COUNT_OUT              (count),
    .COUNT_TICK_OUT         (tick),
    .UPDATE_FLAG_PULSE_OUT  (upd),
    .COMPARE_FLAG_PULSE_OUT (cmpf),
    .COUNT_DOWN_OUT         (down),
    .ACTIVE_DYN_OUT         (act),
    .OUT_ENABLE_POL_OUT     (oep_q),
    .DEADTIME_DIV_OUT       (dtd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;

  // ceiling far above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic do_sync();
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("sync_count", 32'h0000_0000, count);
    `CHK("sync_load", dyn.reload, act.reload);
    @(posedge clk);
    sync <= 1'b0;
  endtask : do_sync

  // cycles up to the next update pulse, with ticks and compare pulses seen
  task automatic wait_upd(output int g, output logic [31:0] c, output int nc, output int nt);
    g  = 0;
    nc = 0;
    nt = 0;
    do begin
      @(posedge clk);
      #1;
      g++;
      if (tick === 1'b1) nt++;
      if (cmpf[0] === 1'b1) begin
        nc++;
        `CHK("cmp_at", dyn.compare[31:0], count);
      end
    end while (upd !== 1'b1 && g < 1000);
    c = count;
    `CHK("cmp_hi", 5'h00, cmpf[5:1]);
  endtask : wait_upd

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    rd(ptb_pkg::ADDR_CTRL, d);
    `CHK("ctrl_rst", 32'(ptb_pkg::CTRL_RST), d);
    rd(ptb_pkg::ADDR_PSC, d);
    `CHK("psc_rst", 32'h0000_0000, d);
    wr(ptb_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    wr(4'hF, 32'h0000_0000);
    rd(ptb_pkg::ADDR_CTRL, d);
    `CHK("ctrl_mask", 32'(ptb_pkg::CTRL_MASK), d);
    `CHK("dt_div", 2'b11, dtd);
    rd(4'hF, d);
    `CHK("unmapped", 32'h0000_0000, d);
    wr(ptb_pkg::ADDR_PSC, 32'h0000_0001);
    rd(ptb_pkg::ADDR_PSC, d);
    `CHK("psc", 32'h0000_0001, d);
    $display("done regs");
  endtask : t_regs

  // up run leaves enable off and update disable, single pulse set: must not matter
  task automatic t_edge(input logic dir);
    int          g;
    int          nc;
    int          nt;
    logic [31:0] c;
    wr(ptb_pkg::ADDR_CTRL, dir ? 32'h0000_0091 : 32'h0000_008E);
    do_sync();
    wait_upd(g, c, nc, nt);
    wait_upd(g, c, nc, nt);
    `CHK("edge_wrap", dir ? 32'h0000_0003 : 32'h0000_0000, c);
    `CHK("edge_gap", 8, g);
    `CHK("edge_ticks", 4, nt);
    `CHK("edge_cmp", 1, nc);
    `CHK("edge_dir", dir, down);
    $display("done edge dir %0d", dir);
  endtask : t_edge

  task automatic t_center(input logic [1:0] alignment_select);
    int          g;
    int          nc;
    int          nt;
    logic [31:0] c;
    logic [31:0] c0;
    wr(ptb_pkg::ADDR_CTRL, 32'h0000_0081 | (32'(alignment_select) << 5));
    do_sync();
    wait_upd(g, c, nc, nt);
    for (int h = 0; h < 2; h++) begin
      c0 = c;
      wait_upd(g, c, nc, nt);
      `CHK("ctr_gap", 6, g);
      `CHK("ctr_end", (c0 === 32'h0000_0000) ? 32'h0000_0003 : 32'h0000_0000, c);
      `CHK("ctr_cmp", (c === 32'h0000_0000) ? int'(alignment_select[0]) : int'(alignment_select[1]), nc);
      `CHK("ctr_dir", (c === 32'h0000_0003) ? 1'b1 : 1'b0, down);
    end
    $display("done center %0d", alignment_select);
  endtask : t_center

  task automatic t_oep();
    @(posedge clk);
    oep <= 16'hA5C3;
    @(posedge clk);
    #1;
    `CHK("oep", 16'hA5C3, oep_q);
    $display("done oep");
  endtask : t_oep

  task automatic t_preload();
    int          g;
    int          nc;
    int          nt;
    logic [31:0] c;
    wr(ptb_pkg::ADDR_CTRL, 32'h0000_0081);
    do_sync();
    wait_upd(g, c, nc, nt);
    @(posedge clk);
    dyn.reload         <= 32'h0000_0005;
    dyn.compare[63:32] <= 32'h0000_0009;
    dyn.oc_mode        <= 24'h00_0006;
    @(posedge clk);
    #1;
    `CHK("held", 32'h0000_0003, act.reload);
    `CHK("held_cmp", 32'hFFFF_FFFF, act.compare[63:32]);
    `CHK("held_mode", 24'h00_0000, act.oc_mode);
    wait_upd(g, c, nc, nt);
    `CHK("new_cmp", 32'h0000_0009, act.compare[63:32]);
    `CHK("new_mode", 24'h00_0006, act.oc_mode);
    wait_upd(g, c, nc, nt);
    `CHK("new_gap", 12, g);
    rd(ptb_pkg::ADDR_RELOAD, c);
    `CHK("rd_reload", 32'h0000_0005, c);
    // off-tick cycle, counting up: both status bits low
    rd(ptb_pkg::ADDR_STATUS, c);
    `CHK("rd_status", 32'h0000_0000, c);
    rd(ptb_pkg::ADDR_COUNT, c);
    `CHK("rd_count", 32'h0000_0002, c);
    $display("done preload");
  endtask : t_preload

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk               = 1'b0;
    rst               = 1'b1;
    bus               = '0;
    dyn               = '0;
    dyn.compare       = '1;
    dyn.compare[31:0] = 32'h0000_0002;
    dyn.reload        = 32'h0000_0003;
    oep               = 16'h0000;
    sync              = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("rst_count", INIT, count);
    `CHK("rst_dir", 1'b0, down);
    `CHK("rst_upd", 1'b0, upd);
    @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_edge(1'b0);
    t_edge(1'b1);
    for (int m = 1; m < 4; m++) begin
      t_center(2'(m));
    end
    t_oep();
    t_preload();
    give_verdict();
  end
endmodule : ptb_timer_base_test
